// ---- qsb_defines.svh ----
// constants for the quad-rate burst static ram port
// assumes K and /K are complementary clocks from the controller
// Operation
// - write: w low, r high; beats K,/K,K,/K
// - read data from /K two cycles later
// - selects on K only; data both edges
// - read outputs float from power-up on
// - no same request on consecutive K edges
// - four byte lanes gate 36-bit beats
// - two byte lanes gate 18-bit beats
// - each beat uses its own lane enables
// - two low address bits count 0..3
// - read and write bursts overlap if started on different K edges
// - both selects low: read only; right after a read the read select is ignored and the write is taken
// - burst sequencing advances on K
// - valid half cycle ahead, edge aligned
// - echo clocks always run
`ifndef QSB_DEFINES_SVH
`define QSB_DEFINES_SVH
`define QSB_DW        36
`define QSB_LANE_W    9
`define QSB_LANES     4
`define QSB_BAW       18
`define QSB_MAW       20
`define QSB_BEATS     4
`define QSB_FIFO_D    2
`define QSB_BEAT0     2'h0
`define QSB_BEAT1     2'h1
`define QSB_BEAT2     2'h2
`define QSB_BEAT3     2'h3
`define QSB_HALF_MASK 4'hc
`define QSB_NO_LANES  4'h0
`define QSB_WORD_ZERO 36'h0_0000_0000
`endif

// ---- qsb_pkg.sv ----
// types shared by the burst port modules
// assumes qsb_defines.svh is on the include path
`include "qsb_defines.svh"
package qsb_pkg;
  typedef logic [`QSB_DW-1:0]    qsb_word_t;
  typedef logic [`QSB_LANES-1:0] qsb_lane_t;
  typedef logic [`QSB_BAW-1:0]   qsb_baddr_t;
  typedef logic [`QSB_MAW-1:0]   qsb_maddr_t;

  typedef struct packed {
    qsb_word_t data;
    qsb_lane_t lane_n;
  } qsb_beat_s;

  typedef struct packed {
    logic       en;
    qsb_maddr_t addr;
    qsb_beat_s  beat;
  } qsb_wport_s;

  typedef struct packed {
    logic                             r1;
    qsb_baddr_t                       r1_a;
    logic                             r2;
    logic                             r3;
    logic                             r4;
    logic [`QSB_BEATS-1:0][`QSB_DW-1:0] rbuf;
    logic [`QSB_BEATS-2:0][`QSB_DW-1:0] tail;
    qsb_word_t                        nword;
    qsb_word_t                        kword;
    logic                             n_oe_req;
    logic                             oe_k;
    logic                             valid;
    logic                             w1;
    qsb_baddr_t                       w1_a;
    logic                             w2;
    qsb_baddr_t                       w2_a;
    logic                             w3;
    qsb_baddr_t                       w3_a;
    logic                             done_req;
    qsb_baddr_t                       done_addr;
    logic                             ack_s1;
    logic                             ack_s2;
    logic                             lost;
  } qsb_kst_s;

  typedef struct packed {
    qsb_beat_s cap;
    qsb_word_t q;
    logic      oe;
  } qsb_knst_s;

  typedef struct packed {
    logic                                 s1;
    logic                                 s2;
    logic                                 ack;
    logic [`QSB_FIFO_D-1:0][`QSB_BAW-1:0] mem;
    logic                                 wptr;
    logic                                 rptr;
    logic [1:0]                           cnt;
    logic                                 vld;
  } qsb_mst_s;
endpackage

// ---- qsb_port.sv ----
// burst port logic: /K half, completion buffer and K-side top
// assumes K and /K complementary; i_mclk unrelated in phase
`timescale 1ns/100ps
`default_nettype none
`include "qsb_defines.svh"

module qsb_kn_half (
  input  wire logic              i_kclk_n,
  input  wire logic              i_rst_n,
  input  wire qsb_pkg::qsb_beat_s i_beat,
  input  wire qsb_pkg::qsb_word_t i_word,
  input  wire logic              i_oe_req,
  output logic                   o_oe,
  output qsb_pkg::qsb_word_t     o_q,
  output qsb_pkg::qsb_beat_s     o_cap
);
  qsb_pkg::qsb_knst_s st;
  qsb_pkg::qsb_knst_s next_st;

  always_comb begin
    next_st = st;
    next_st.cap = i_beat;
    next_st.q  = i_word;
    next_st.oe = i_oe_req;
  end

  always_ff @(posedge i_kclk_n or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_oe  = st.oe;
  assign o_q   = st.q;
  assign o_cap = st.cap;
endmodule

module qsb_done_side (
  input  wire logic               i_mclk,
  input  wire logic               i_rst_n,
  input  wire logic               i_req,
  input  wire qsb_pkg::qsb_baddr_t i_addr,
  input  wire logic               i_ready,
  output logic                    o_ack,
  output logic                    o_valid,
  output qsb_pkg::qsb_baddr_t     o_addr
);
  qsb_pkg::qsb_mst_s st;
  qsb_pkg::qsb_mst_s next_st;
  logic              push;
  logic              pop;

  always_comb begin
    next_st = st;
    next_st.s1 = i_req;
    next_st.s2 = st.s1;
    // full buffer holds the ack back, so the K side drops later reports
    push = (st.s2 != st.ack) && (st.cnt != 2'(`QSB_FIFO_D));
    pop  = st.vld && i_ready;
    if (push) begin
      next_st.mem[st.wptr] = i_addr;
      next_st.wptr = ~st.wptr;
      next_st.ack  = st.s2;
    end
    if (pop) begin
      next_st.rptr = ~st.rptr;
    end
    next_st.cnt = st.cnt + 2'(push) - 2'(pop);
    next_st.vld = (next_st.cnt != 2'h0);
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_ack   = st.ack;
  assign o_valid = st.vld;
  assign o_addr  = st.mem[st.rptr];
endmodule

// two-flop synchroniser for a level from a pin
module qsb_sync (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_d,
  output logic      o_q
);
  logic [1:0] st;
  logic [1:0] next_st;

  always_comb begin
    // only the second stage is read downstream
    next_st = {st[0], i_d};
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= 2'h0;
    end else begin
      st <= next_st;
    end
  end

  assign o_q = st[1];
endmodule

module qsb_port (
  input  wire logic               i_mclk,
  input  wire logic               i_rst_n,
  input  wire logic               i_kclk,
  input  wire logic               i_kclk_n,
  input  wire logic               i_half_width,
  input  wire qsb_pkg::qsb_baddr_t i_addr,
  input  wire logic               i_read_sel_n,
  input  wire logic               i_write_sel_n,
  input  wire qsb_pkg::qsb_lane_t  i_byte_lane_write_n,
  input  wire qsb_pkg::qsb_word_t  i_wdata,
  input  wire logic               i_done_ready,
  output qsb_pkg::qsb_word_t      o_read_data,
  output logic                    o_read_oe,
  output logic                    o_read_output_valid,
  output logic                    o_echo_clock_true,
  output logic                    o_echo_clock_comp,
  output logic                    o_done_valid,
  output qsb_pkg::qsb_baddr_t     o_done_addr,
  output logic                    o_done_lost
);
  qsb_pkg::qsb_kst_s  st;
  qsb_pkg::qsb_kst_s  next_st;
  qsb_pkg::qsb_word_t mem [0:(1<<`QSB_MAW)-1];
  qsb_pkg::qsb_beat_s pin_beat;
  qsb_pkg::qsb_beat_s cap_beat;
  qsb_pkg::qsb_word_t kn_q;
  qsb_pkg::qsb_wport_s wp0;
  qsb_pkg::qsb_wport_s wp1;
  logic               kn_oe;
  logic               done_ack;
  logic               rd_go;
  logic               wr_go;
  logic               pend;
  logic               half_q;

  // strap is a pin; settle it on K before use
  qsb_sync u_half (
    .i_clk   (i_kclk),
    .i_rst_n (i_rst_n),
    .i_d     (i_half_width),
    .o_q     (half_q)
  );

  assign pin_beat.data   = i_wdata;
  assign pin_beat.lane_n = i_byte_lane_write_n |
                           (half_q ? `QSB_HALF_MASK : `QSB_NO_LANES);

  qsb_kn_half u_kn (
    .i_kclk_n (i_kclk_n),
    .i_rst_n  (i_rst_n),
    .i_beat   (pin_beat),
    .i_word   (st.nword),
    .i_oe_req (st.n_oe_req),
    .o_oe     (kn_oe),
    .o_q      (kn_q),
    .o_cap    (cap_beat)
  );

  qsb_done_side u_done (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_req   (st.done_req),
    .i_addr  (st.done_addr),
    .i_ready (i_done_ready),
    .o_ack   (done_ack),
    .o_valid (o_done_valid),
    .o_addr  (o_done_addr)
  );

  always_comb begin
    // second request on next edge dropped
    // read select ignored right after a read
    rd_go = !i_read_sel_n && !st.r1;
    wr_go = !i_write_sel_n && !st.w1 && !rd_go;
    // A+0 from pins on K(t+1), A+2 on K(t+2)
    // lanes travel with their own beat
    wp0.en   = st.w1 || st.w2;
    wp0.addr = st.w1 ? {st.w1_a, `QSB_BEAT0} : {st.w2_a, `QSB_BEAT2};
    wp0.beat = pin_beat;
    // /K beats A+1, A+3 from the capture half
    wp1.en   = st.w2 || st.w3;
    wp1.addr = st.w2 ? {st.w2_a, `QSB_BEAT1} : {st.w3_a, `QSB_BEAT3};
    wp1.beat = cap_beat;
    pend     = st.done_req != st.ack_s2;
  end

  always_ff @(posedge i_kclk) begin
    for (int l = 0; l < `QSB_LANES; l++) begin
      if (wp0.en && !wp0.beat.lane_n[l]) begin
        mem[wp0.addr][l*`QSB_LANE_W +: `QSB_LANE_W] <=
          wp0.beat.data[l*`QSB_LANE_W +: `QSB_LANE_W];
      end
      if (wp1.en && !wp1.beat.lane_n[l]) begin
        mem[wp1.addr][l*`QSB_LANE_W +: `QSB_LANE_W] <=
          wp1.beat.data[l*`QSB_LANE_W +: `QSB_LANE_W];
      end
    end
  end

  always_comb begin
    next_st = st;
    next_st.r1   = rd_go;
    next_st.r1_a = rd_go ? i_addr : st.r1_a;
    next_st.r2   = st.r1;
    next_st.r3   = st.r2;
    next_st.r4   = st.r3;
    if (st.r1) begin
      for (int b = 0; b < `QSB_BEATS; b++) begin
        next_st.rbuf[b] = mem[{st.r1_a, 2'(b)}];
      end
    end
    next_st.n_oe_req = st.r2 || st.r3;
    next_st.oe_k     = st.r3 || st.r4;
    // A+0 at /K(t+2), A+1 at K(t+3)
    if (st.r2) begin
      next_st.nword = st.rbuf[0];
      next_st.tail  = st.rbuf[`QSB_BEATS-1:1];
    end else if (st.r3) begin
      next_st.nword = st.tail[1];
    end
    if (st.r3) begin
      next_st.kword = st.tail[0];
    end else if (st.r4) begin
      next_st.kword = st.tail[2];
    end
    next_st.valid = st.r2 || st.r3;
    next_st.w1   = wr_go;
    next_st.w1_a = wr_go ? i_addr : st.w1_a;
    next_st.w2   = st.w1;
    next_st.w2_a = st.w1_a;
    next_st.w3   = st.w2;
    next_st.w3_a = st.w2_a;
    // completion crossing; a busy handshake loses the report
    next_st.ack_s1 = done_ack;
    next_st.ack_s2 = st.ack_s1;
    if (st.w3) begin
      if (pend) begin
        next_st.lost = 1'b1;
      end else begin
        next_st.done_req  = ~st.done_req;
        next_st.done_addr = st.w3_a;
      end
    end
  end

  // no edges, no change of state
  always_ff @(posedge i_kclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // enables low from reset until a read
  assign o_read_oe           = i_kclk ? st.oe_k : kn_oe;
  assign o_read_data         = i_kclk ? st.kword : kn_q;
  assign o_read_output_valid = st.valid;
  // echo clocks follow K without gaps
  assign o_echo_clock_true   = i_kclk;
  assign o_echo_clock_comp   = i_kclk_n;
  assign o_done_lost         = st.lost;
endmodule
`default_nettype wire

// ---- qsb_port_props.sv ----
// read-side checker for qsb_port on the K clock
// assumes binding to qsb_port; sees its ports only
`timescale 1ns/100ps
`default_nettype none
module qsb_port_props (
  input wire logic i_kclk,
  input wire logic i_kclk_n,
  input wire logic i_rst_n,
  input wire logic i_read_sel_n,
  input wire logic o_read_oe,
  input wire logic o_read_output_valid,
  input wire logic o_echo_clock_true,
  input wire logic o_echo_clock_comp
);
  logic rtk_q;
  logic rtk;
  assign rtk = !i_read_sel_n && !rtk_q;
  always_ff @(posedge i_kclk or negedge i_rst_n) begin
    if (!i_rst_n) rtk_q <= 1'h0;
    else rtk_q <= rtk;
  end
  default clocking @(posedge i_kclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_rd; rtk; endsequence
  sequence s_lone; rtk ##2 !rtk; endsequence
  property p_valid_on; s_rd |-> ##3 o_read_output_valid [*2]; endproperty
  property p_valid_off; s_lone |-> ##3 !o_read_output_valid; endproperty
  property p_valid_cause; $rose(o_read_output_valid) |-> $past(rtk, 3); endproperty
  property p_oe_on; s_rd |-> ##3 o_read_oe [*2]; endproperty
  property p_oe_off; s_lone |-> ##3 !o_read_oe; endproperty
  property p_oe_cause; $rose(o_read_oe) |-> $past(rtk, 3); endproperty
  property p_float; (!rtk) [*5] |-> !o_read_oe; endproperty
  property p_echo;
    o_echo_clock_true == i_kclk && o_echo_clock_comp == i_kclk_n;
  endproperty
  a_valid_on: assert property (p_valid_on) else $error("valid late");
  a_valid_off: assert property (p_valid_off) else $error("valid long");
  a_valid_cause: assert property (p_valid_cause) else $error("stray valid");
  a_oe_on: assert property (p_oe_on) else $error("drive late");
  a_oe_off: assert property (p_oe_off) else $error("drive long");
  a_oe_cause: assert property (p_oe_cause) else $error("stray drive");
  a_float: assert property (p_float) else $error("not floating");
  a_echo: assert property (p_echo) else $error("echo stopped");
endmodule
bind qsb_port qsb_port_props u_props (.i_kclk(i_kclk), .i_kclk_n(i_kclk_n),
  .i_rst_n(i_rst_n), .i_read_sel_n(i_read_sel_n), .o_read_oe(o_read_oe),
  .o_read_output_valid(o_read_output_valid), .o_echo_clock_true(o_echo_clock_true),
  .o_echo_clock_comp(o_echo_clock_comp));
`default_nettype wire

// ---- qsb_ctl_model.sv ----
// memory controller model: K pair, selects, lanes, data
// assumes the bench calls wr and rd; one of each at a time
`timescale 1ns/100ps
`default_nettype none
module qsb_ctl_model (
  output logic               o_k,
  output logic               o_kn,
  output qsb_pkg::qsb_baddr_t o_addr,
  output logic               o_rsel_n,
  output logic               o_wsel_n,
  output qsb_pkg::qsb_lane_t  o_lane_n,
  output qsb_pkg::qsb_word_t  o_wd,
  input  wire logic          i_oe,
  input  wire qsb_pkg::qsb_word_t i_q
);
  initial begin
    o_k = 1'h0;
    o_kn = 1'h1;
    o_addr = 18'h0_0000;
    o_rsel_n = 1'h1;
    o_wsel_n = 1'h1;
    o_lane_n = 4'hf;
    o_wd = 36'h0_0000_0000;
    forever begin
      #16;
      o_k = ~o_k;
      o_kn = ~o_kn;
    end
  end
  task automatic wr(input qsb_pkg::qsb_baddr_t a, input qsb_pkg::qsb_word_t d[4],
                    input qsb_pkg::qsb_lane_t l[4]);
    @(posedge o_k);
    o_wsel_n <= 1'h0;
    o_addr <= a;
    @(posedge o_k);
    o_wsel_n <= 1'h1;
    o_wd <= d[0];
    o_lane_n <= l[0];
    for (int i = 1; i < 4; i++) begin
      if (i[0]) @(posedge o_k);
      else @(posedge o_kn);
      o_wd <= d[i];
      o_lane_n <= l[i];
    end
    @(posedge o_kn);
    // released data flips, never holds; lanes go high
    o_wd <= ~d[3];
    o_lane_n <= 4'hf;
  endtask
  // read, optional write select or second read
  task automatic rd(input qsb_pkg::qsb_baddr_t a, input logic w, input logic dbl,
                    output qsb_pkg::qsb_word_t q[4], output logic oe);
    @(posedge o_k);
    o_rsel_n <= 1'h0;
    o_addr <= a;
    if (w) o_wsel_n <= 1'h0;
    if (w) o_lane_n <= 4'h0;
    @(posedge o_k);
    o_rsel_n <= ~dbl;
    if (w) o_wsel_n <= 1'h1;
    if (dbl) o_addr <= ~a;
    @(posedge o_k);
    o_rsel_n <= 1'h1;
    @(posedge o_k);
    oe = 1'h1;
    for (int i = 0; i < 4; i++) begin
      if (i[0]) @(posedge o_k);
      else @(posedge o_kn);
      #8;
      q[i] = i_q;
      oe &= i_oe;
    end
    if (w) o_lane_n <= 4'hf;
  endtask
endmodule
`default_nettype wire

// ---- qsb_port_test.sv ----
// self-checking bench for qsb_port with the controller model
// assumes K from the model at 32 ns; i_mclk made here
`timescale 1ns/100ps
`default_nettype none
module qsb_port_test;
  logic mclk, rst_n, k, kn, rs_n, ws_n, half, rdy, oe, vld, ek, ekn, dv, lost;
  qsb_pkg::qsb_baddr_t a, da;
  qsb_pkg::qsb_lane_t  ln;
  qsb_pkg::qsb_word_t  wd, q;
  qsb_pkg::qsb_word_t  mem [qsb_pkg::qsb_maddr_t];
  qsb_pkg::qsb_lane_t  all [4] = '{4'h0, 4'h0, 4'h0, 4'h0};
  int miscompares, n_checks;
  qsb_ctl_model ctl (.o_k(k), .o_kn(kn), .o_addr(a), .o_rsel_n(rs_n), .o_wsel_n(ws_n),
    .o_lane_n(ln), .o_wd(wd), .i_oe(oe), .i_q(q));
  qsb_port dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_kclk(k), .i_kclk_n(kn),
    .i_half_width(half), .i_addr(a), .i_read_sel_n(rs_n), .i_write_sel_n(ws_n),
    .i_byte_lane_write_n(ln), .i_wdata(wd), .i_done_ready(rdy), .o_read_data(q),
    .o_read_oe(oe), .o_read_output_valid(vld), .o_echo_clock_true(ek),
    .o_echo_clock_comp(ekn), .o_done_valid(dv), .o_done_addr(da), .o_done_lost(lost));
  task automatic cmp(input qsb_pkg::qsb_word_t got, input qsb_pkg::qsb_word_t want);
    n_checks++;
    if (got !== want) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic complete_run;
    if (miscompares == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input qsb_pkg::qsb_baddr_t ad, input qsb_pkg::qsb_word_t s,
                    input qsb_pkg::qsb_lane_t l[4]);
    qsb_pkg::qsb_word_t d[4];
    for (int i = 0; i < 4; i++) begin
      d[i] = s ^ {4{9'(i)}};
      for (int j = 0; j < 4; j++)
        if (!l[i][j] && !(half && j > 1)) mem[{ad, 2'(i)}][j*9 +: 9] = d[i][j*9 +: 9];
    end
    ctl.wr(ad, d, l);
  endtask
  task automatic rd(input qsb_pkg::qsb_baddr_t ad, input logic w, input logic dbl);
    qsb_pkg::qsb_word_t r[4];
    logic o;
    ctl.rd(ad, w, dbl, r, o);
    cmp({35'h0, o}, 36'h1);
    for (int i = 0; i < 4; i++) cmp(r[i], mem[{ad, 2'(i)}]);
  endtask
  task automatic done(input qsb_pkg::qsb_baddr_t ad);
    int n = 0;
    while (dv !== 1'h1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    if (n == 200) begin
      miscompares++;
      complete_run();
    end else begin
      cmp({18'h0, da}, {18'h0, ad});
      @(posedge mclk) rdy <= 1'h1;
      @(posedge mclk) rdy <= 1'h0;
      @(negedge mclk);
    end
  endtask
  task automatic sc_basic;
    #2 cmp({35'h0, oe}, 36'h0);
    cmp({34'h0, ek, ekn}, {34'h0, 1'h1, 1'h0});
    wr(18'h0_0010, 36'ha_5a5a_5a5a, all);
    rd(18'h0_0010, 1'h0, 1'h0);
    done(18'h0_0010);
  endtask
  task automatic sc_lanes;
    wr(18'h0_0010, 36'h3_c3c3_c3c3, '{4'he, 4'hd, 4'h7, 4'hf});
    rd(18'h0_0010, 1'h0, 1'h0);
    done(18'h0_0010);
    @(posedge k) half <= 1'h1;
    repeat (3) @(posedge k);
    wr(18'h0_0010, 36'hf_0f0f_0f0f, all);
    rd(18'h0_0010, 1'h0, 1'h0);
    done(18'h0_0010);
    @(posedge k) half <= 1'h0;
    repeat (3) @(posedge k);
  endtask
  task automatic sc_overlap;
    wr(18'h0_0020, 36'h1_2345_6789, all);
    done(18'h0_0020);
    fork
      rd(18'h0_0020, 1'h0, 1'h0);
      begin
        @(posedge k);
        wr(18'h0_0030, 36'h9_8765_4321, all);
      end
    join
    rd(18'h0_0030, 1'h0, 1'h0);
    rd(18'h0_0020, 1'h1, 1'h1);
    rd(18'h0_0020, 1'h0, 1'h0);
    wr(18'h0_0040, 36'h5_5555_aaaa, all);
    wr(18'h0_0050, 36'ha_aaaa_5555, all);
    done(18'h0_0030);
    done(18'h0_0040);
    done(18'h0_0050);
    cmp({35'h0, lost}, 36'h0);
  endtask
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    rst_n = 1'h0;
    half = 1'h0;
    rdy = 1'h0;
    miscompares = 0;
    n_checks = 0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'h1;
    repeat (3) @(posedge k);
    sc_basic();
    sc_lanes();
    sc_overlap();
    complete_run();
  end
endmodule
`default_nettype wire
